// ### crp_reset_ctrl.sv
// chip reset sequencer: pin hold, boot capture, timed release
`timescale 1ns/100ps
`default_nettype none
module crp_reset_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic resetPinN,
    input wire logic bootSourceSelect,
    input wire logic flashSecured,
    input wire logic pullupDisableReset,
    output logic chipReset,
    output logic resetStateOutputN,
    output logic bootExternal,
    output logic resetPullupEnable
);
    typedef struct packed {
        crp_pkg::crp_state_e state;
        logic [crp_pkg::CNT_W-1:0] cnt;
        logic boot;
        logic intRst;
        logic rstOutN;
        logic pullEn;
    } crp_ctrl_s;

    crp_ctrl_s st_q;
    crp_ctrl_s st_d;
    logic pinN;
    logic pinBoot;

    crp_sync_if sif ();
    assign sif.raw = {bootSourceSelect, resetPinN};

    crp_pin_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pins(sif.syncer)
    );

    assign pinN = sif.filt[crp_pkg::PIN_RESET_N];
    assign pinBoot = sif.filt[crp_pkg::PIN_BOOT];

    always_comb begin
        st_d = st_q;
        case (st_q.state)
            crp_pkg::ST_HOLD: begin
                st_d.cnt = crp_pkg::CNT_RESET;
                if (pinN) begin
                    // mode latched at the synced release
                    st_d.boot = pinBoot & ~flashSecured;
                    st_d.state = crp_pkg::ST_COUNT;
                end
            end
            crp_pkg::ST_COUNT: begin
                if (!pinN) begin
                    st_d.state = crp_pkg::ST_HOLD;
                    st_d.cnt = crp_pkg::CNT_RESET;
                end else if (st_q.cnt == crp_pkg::RELEASE_LAST) begin
                    st_d.state = crp_pkg::ST_RUN;
                end else begin
                    st_d.cnt = st_q.cnt + 6'h01;
                end
            end
            crp_pkg::ST_RUN: begin
                if (!pinN) begin
                    st_d.state = crp_pkg::ST_HOLD;
                end
            end
            default: begin
                st_d.state = crp_pkg::ST_HOLD;
            end
        endcase
        st_d.intRst = (st_d.state != crp_pkg::ST_RUN);
        st_d.rstOutN = ~st_d.intRst;
        st_d.pullEn = st_d.intRst | ~pullupDisableReset;
    end

    // async reset is the power-on reset: pin-reset hold state with the boot mode cleared to 0
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= '{crp_pkg::ST_HOLD, crp_pkg::CNT_RESET, 1'b0, 1'b1, 1'b0, 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    assign chipReset = st_q.intRst;
    assign resetStateOutputN = st_q.rstOutN;
    assign bootExternal = st_q.boot;
    assign resetPullupEnable = st_q.pullEn;

    // helper: cycles spent counting
    logic [crp_pkg::CNT_W:0] countLen;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            countLen <= 7'h00;
        end else if (st_q.state == crp_pkg::ST_COUNT) begin
            countLen <= countLen + 7'h01;
        end else begin
            countLen <= 7'h00;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_hold_while_low: assert property ((!pinN) |=> chipReset)
        else $error("chip reset not held while pin low");
    a_boot_capture: assert property ((st_q.state == crp_pkg::ST_HOLD && pinN)
        |=> bootExternal == $past(pinBoot & ~flashSecured))
        else $error("boot mode not captured at release");
    a_release_count: assert property ($fell(chipReset)
        |-> countLen == {1'b0, crp_pkg::RELEASE_CLOCKS})
        else $error("release count wrong");
    a_por_hold: assert property ($past(rst) |-> chipReset ##1 chipReset)
        else $error("power-on reset not held");
    a_out_mirror: assert property (resetStateOutputN == !chipReset)
        else $error("reset output does not mirror internal reset");
    a_pullup_ctrl: assert property ((!chipReset && $past(!chipReset))
        |-> resetPullupEnable == !$past(pullupDisableReset))
        else $error("pull-up control wrong");
    a_pullup_reset: assert property (chipReset |-> resetPullupEnable)
        else $error("pull-up off during reset");
    a_secure_block: assert property ((st_q.state == crp_pkg::ST_HOLD && pinN && flashSecured)
        |=> !bootExternal)
        else $error("external boot while flash secured");
    a_count_restart: assert property ((st_q.state == crp_pkg::ST_COUNT && !pinN)
        |=> st_q.state == crp_pkg::ST_HOLD && st_q.cnt == crp_pkg::CNT_RESET
        ##1 chipReset)
        else $error("reassertion did not restart sequence");


    a_state_onehot: assert property ($onehot(st_q.state))
        else $error("sequencer state not one-hot");
    a_count_range: assert property ((st_q.state == crp_pkg::ST_COUNT)
        |-> st_q.cnt <= crp_pkg::RELEASE_LAST)
        else $error("release counter out of range");
    a_count_start: assert property ((st_q.state == crp_pkg::ST_HOLD && pinN)
        |=> st_q.state == crp_pkg::ST_COUNT && st_q.cnt == crp_pkg::CNT_RESET)
        else $error("count did not start from zero at synced release");
    a_count_step: assert property ((st_q.state == crp_pkg::ST_COUNT && pinN
        && st_q.cnt != crp_pkg::RELEASE_LAST)
        |=> st_q.cnt == $past(st_q.cnt) + 6'h01)
        else $error("release counter skipped a step");
    a_run_released: assert property ((st_q.state == crp_pkg::ST_RUN) |-> !chipReset)
        else $error("internal reset held while running");
    a_boot_stable: assert property ((st_q.state != crp_pkg::ST_HOLD)
        |=> $stable(bootExternal))
        else $error("boot mode changed outside capture");
    a_por_values: assert property ($past(rst)
        |-> resetPullupEnable && !bootExternal && !resetStateOutputN)
        else $error("power-on reset values wrong");

    c_release: cover property ($fell(chipReset));
    c_secure_boot: cover property ($fell(chipReset) && flashSecured);
    c_restart: cover property (st_q.state == crp_pkg::ST_COUNT && !pinN);
    c_ext_boot: cover property ($fell(chipReset) && bootExternal);
    c_rerun_reset: cover property (st_q.state == crp_pkg::ST_RUN && !pinN);
endmodule : crp_reset_ctrl
`default_nettype wire

// ### crp_pkg.sv
// constants and types for the chip reset pin control block
// How it works
// - reset pin low holds everything in reset
// - boot-select level captured at pin release
// - internal reset released after fixed clock count
// - power-on reset acts like pin reset
// - reset output pin mirrors internal reset
// - pin pull-up on after reset, software disables
// - high boot-select boots external unless flash secured
package crp_pkg;
    localparam int SYNC_BITS = 2;
    localparam int PIN_RESET_N = 0;
    localparam int PIN_BOOT = 1;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] RELEASE_CLOCKS = 6'h20;
    localparam logic [CNT_W-1:0] RELEASE_LAST = 6'h1F;
    localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
    localparam logic [SYNC_BITS-1:0] SYNC_RESET = 2'h0;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_COUNT = 3'b010,
        ST_RUN = 3'b100
    } crp_state_e;
endpackage : crp_pkg

// ### crp_sync_if.sv
// bundle between the pin synchroniser and the sequencer
`timescale 1ns/100ps
`default_nettype none
interface crp_sync_if;
    logic [crp_pkg::SYNC_BITS-1:0] raw;
    logic [crp_pkg::SYNC_BITS-1:0] filt;
    modport syncer (input raw, output filt);
    modport user (output raw, input filt);
endinterface : crp_sync_if
`default_nettype wire

// ### crp_pin_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module crp_pin_sync (
    input wire logic sys_clk,
    input wire logic rst,
    crp_sync_if.syncer pins
);
    typedef struct packed {
        logic [crp_pkg::SYNC_BITS-1:0] s1;
        logic [crp_pkg::SYNC_BITS-1:0] s2;
        logic [crp_pkg::SYNC_BITS-1:0] s3;
        logic [crp_pkg::SYNC_BITS-1:0] filt;
    } crp_sync_s;

    crp_sync_s st_q;
    crp_sync_s st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = pins.raw;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // a change counts once stages two and three agree
        for (int i = 0; i < crp_pkg::SYNC_BITS; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.filt[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= '{crp_pkg::SYNC_RESET, crp_pkg::SYNC_RESET,
                      crp_pkg::SYNC_RESET, crp_pkg::SYNC_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign pins.filt = st_q.filt;
endmodule : crp_pin_sync
`default_nettype wire

// ### crp_board_model.sv
// board reset circuitry driving the chip reset and boot pins
`timescale 1ns/100ps
`default_nettype none
module crp_board_model (
    input wire logic holdReset,
    input wire logic bootHigh,
    input wire logic debugOnly,
    output logic resetPinN,
    output logic bootSourceSelect,
    output logic testResetN
);
    assign resetPinN = ~holdReset;
    // full reset pulls the test port with the chip; debug reset leaves it alone
    assign testResetN = debugOnly | ~holdReset;
    assign bootSourceSelect = bootHigh;
endmodule : crp_board_model
`default_nettype wire

// ### crp_reset_ctrl_test.sv
// self-checking bench for the chip reset sequencer
`timescale 1ns/100ps
`default_nettype none
module crp_reset_ctrl_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic holdReset = 1'b1;
    logic bootHigh = 1'b0;
    logic flashSecured = 1'b0;
    logic pullupDisableReset = 1'b0;
    logic debugOnly = 1'b0;
    wire logic testResetN;
    wire logic resetPinN;
    wire logic bootSourceSelect;
    logic chipReset, resetStateOutputN, bootExternal, resetPullupEnable;
    int errors = 0;
    int tests_run = 0;
    int n;
    always #2.5 sys_clk = ~sys_clk;
    crp_board_model i_board (.holdReset(holdReset), .bootHigh(bootHigh),
        .debugOnly(debugOnly), .resetPinN(resetPinN), .bootSourceSelect(bootSourceSelect),
        .testResetN(testResetN));
    crp_reset_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .resetPinN(resetPinN),
        .bootSourceSelect(bootSourceSelect), .flashSecured(flashSecured),
        .pullupDisableReset(pullupDisableReset), .chipReset(chipReset),
        .resetStateOutputN(resetStateOutputN), .bootExternal(bootExternal),
        .resetPullupEnable(resetPullupEnable));
    task automatic check(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : check
    task automatic cycles(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : cycles
    task automatic wait_release();
        n = 0;
        holdReset = 1'b0;
        while (chipReset !== 1'b0 && n < 80) begin
            cycles(1);
            n++;
        end
        check("release count", 1'b1, n >= 34 && n <= 40);
        check("reset out high", 1'b1, resetStateOutputN);
    endtask : wait_release
    task automatic t_boot(input logic b, input logic f, input logic exp);
        holdReset = 1'b1;
        bootHigh = b;
        flashSecured = f;
        cycles(8);
        check("held reset", 1'b1, chipReset);
        check("reset out low", 1'b0, resetStateOutputN);
        check("pullup in reset", 1'b1, resetPullupEnable);
        check("test reset with chip", 1'b0, testResetN);
        wait_release();
        check("boot external", exp, bootExternal);
        bootHigh = ~b;
        cycles(6);
        check("boot kept", exp, bootExternal);
        $display("boot case done");
    endtask : t_boot
    task automatic t_restart();
        debugOnly = 1'b1;
        holdReset = 1'b1;
        cycles(8);
        check("test reset left off", 1'b1, testResetN);
        holdReset = 1'b0;
        cycles(12);
        holdReset = 1'b1;
        cycles(6);
        check("restart held", 1'b1, chipReset);
        wait_release();
        debugOnly = 1'b0;
        $display("restart done");
    endtask : t_restart
    task automatic t_pullup();
        pullupDisableReset = 1'b1;
        cycles(2);
        check("pullup off", 1'b0, resetPullupEnable);
        pullupDisableReset = 1'b0;
        cycles(2);
        check("pullup on", 1'b1, resetPullupEnable);
        $display("pullup done");
    endtask : t_pullup
    task automatic t_por();
        rst = 1'b1;
        cycles(3);
        check("power-on reset", 1'b1, chipReset);
        rst = 1'b0;
        wait_release();
        $display("power-on done");
    endtask : t_por
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    initial begin
        #10000;
        errors++;
        close_out();
    end
    initial begin
        cycles(3);
        rst = 1'b0;
        t_boot(1'b1, 1'b0, 1'b1);
        t_boot(1'b1, 1'b1, 1'b0);
        t_boot(1'b0, 1'b0, 1'b0);
        t_restart();
        t_pullup();
        t_por();
        close_out();
    end
endmodule : crp_reset_ctrl_test
`default_nettype wire
